/* src/dmc_regs.vh */
`ifndef DMC_REGS_VH
`define DMC_REGS_VH
`define DMC_CLK_NS 5
`define DMC_ROW_ADDR_HOLD_NS 10
`define DMC_ROW_TO_COL_DELAY_NS 20
`define DMC_ROW_ACCESS_TIME_NS 100
`define DMC_COL_ACCESS_NS 50
`define DMC_COL_PULSE_NS 55
`define DMC_ROW_PULSE_NS 105
`define DMC_ROW_PRECHARGE_NS 85
`define DMC_READ_HOLD_VS_ROW_NS 20
`define DMC_REFRESH_COL_SETUP_NS 20
`define DMC_REFRESH_COL_HOLD_NS 20
`define DMC_COL_TO_WRITE_DELAY_NS 15
`define DMC_WRITE_PULSE_NS 15
`define DMC_DATA_HOLD_NS 15
`define DMC_PAGE_CYCLE_TIME_NS 100
`define DMC_PAGE_COL_PRECHARGE_NS 40
`define DMC_PRECHARGE_TO_COL_ACTIVE_NS 20
`define DMC_INIT_PAUSE_US 200
`define DMC_INIT_REFRESHES 8
`define DMC_REFRESH_PERIOD_MS 4
`define DMC_ROWS 256
`define DMC_CYC(ns) (((ns) + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_INIT_PAUSE_CYC ((`DMC_INIT_PAUSE_US * 1000) / `DMC_CLK_NS)
`define DMC_REFRESH_INTERVAL_CYC ((`DMC_REFRESH_PERIOD_MS * 1000000 / `DMC_ROWS) / `DMC_CLK_NS)
`define DMC_OP_READ 2'h0
`define DMC_OP_WRITE 2'h1
`define DMC_OP_PARITY_RMW 2'h2
`endif

/* src/dmc_ctrl.v */
`include "dmc_regs.vh"
module dmc_ctrl #(
   parameter INIT_PAUSE_CYC = `DMC_INIT_PAUSE_CYC,
   parameter REFRESH_INTERVAL_CYC = `DMC_REFRESH_INTERVAL_CYC
) (
   input wire clock,
   input wire nrst,
   input wire req_valid,
   input wire [1:0] req_op,
   input wire req_page,
   input wire [17:0] req_addr,
   input wire [8:0] req_wdata,
   output reg req_ready,
   output reg rsp_valid,
   output reg [8:0] rsp_rdata,
   output reg init_done,
   output reg [8:0] mux_addr_pins,
   output reg row_strobe_n,
   output reg col_strobe_n,
   output reg parity_col_strobe_n,
   output reg write_enable_n,
   output reg [7:0] main_data_out,
   output reg main_data_oe,
   input wire [7:0] main_data_in,
   output reg parity_data_in,
   input wire parity_data_out
);
   localparam T_RAH = `DMC_CYC(`DMC_ROW_ADDR_HOLD_NS);
   localparam T_RCD = `DMC_CYC(`DMC_ROW_TO_COL_DELAY_NS);
   localparam T_CAC = `DMC_CYC(`DMC_COL_ACCESS_NS) + 2;
   localparam T_RAC = `DMC_CYC(`DMC_ROW_ACCESS_TIME_NS) + 2;
   localparam T_CAS = `DMC_CYC(`DMC_COL_PULSE_NS);
   localparam T_RAS = `DMC_CYC(`DMC_ROW_PULSE_NS);
   localparam T_RP = `DMC_CYC(`DMC_ROW_PRECHARGE_NS);
   localparam T_RRH = `DMC_CYC(`DMC_READ_HOLD_VS_ROW_NS);
   localparam T_FCS = `DMC_CYC(`DMC_REFRESH_COL_SETUP_NS);
   localparam T_FCH = `DMC_CYC(`DMC_REFRESH_COL_HOLD_NS);
   localparam T_CWD = `DMC_CYC(`DMC_COL_TO_WRITE_DELAY_NS);
   localparam T_WP = `DMC_CYC(`DMC_WRITE_PULSE_NS);
   localparam T_PC = `DMC_CYC(`DMC_PAGE_CYCLE_TIME_NS);
   localparam T_CP = `DMC_CYC(`DMC_PAGE_COL_PRECHARGE_NS);
   localparam T_RPC = `DMC_CYC(`DMC_PRECHARGE_TO_COL_ACTIVE_NS);
   localparam S_PAUSE = 11'h001;
   localparam S_IDLE = 11'h002;
   localparam S_ROW = 11'h004;
   localparam S_COLADDR = 11'h008;
   localparam S_COL = 11'h010;
   localparam S_RMW = 11'h020;
   localparam S_COLUP = 11'h040;
   localparam S_PAGE = 11'h080;
   localparam S_PRE = 11'h100;
   localparam S_REF_SET = 11'h200;
   localparam S_REF_ROW = 11'h400;
   reg [10:0] state_reg;
   reg [31:0] cnt_reg;
   reg [31:0] pc_reg;
   reg [31:0] ras_reg;
   reg [31:0] ref_tmr_reg;
   reg ref_pend_reg;
   reg [3:0] init_cnt_reg;
   reg [1:0] op_reg;
   reg [8:0] row_reg;
   reg [8:0] col_reg;
   reg [8:0] wdata_reg;
   reg [7:0] main_s1_reg;
   reg [7:0] main_s2_reg;
   reg par_s1_reg;
   reg par_s2_reg;
   wire take = req_valid && req_ready;
   wire page_hit = req_valid && req_page && !ref_pend_reg && req_addr[17:9] == row_reg;
   always @(posedge clock)
   begin
      main_s1_reg <= main_data_in;
      main_s2_reg <= main_s1_reg;
      par_s1_reg <= parity_data_out;
      par_s2_reg <= par_s1_reg;
   end
   // refresh scheduler: one row every 4 ms / 256
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         ref_tmr_reg <= 32'h0;
         ref_pend_reg <= 1'b0;
      end
      else
      begin
         if (ref_tmr_reg >= REFRESH_INTERVAL_CYC - 1)
         begin
            ref_tmr_reg <= 32'h0;
            ref_pend_reg <= 1'b1;
         end
         else
         begin
            ref_tmr_reg <= ref_tmr_reg + 32'h1;
            if (state_reg == S_REF_SET && init_done)
               ref_pend_reg <= 1'b0;
         end
      end
   end
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         state_reg <= S_PAUSE;
         cnt_reg <= 32'h0;
         pc_reg <= 32'h0;
         ras_reg <= 32'h0;
         init_cnt_reg <= 4'h0;
         init_done <= 1'b0;
         op_reg <= `DMC_OP_READ;
         row_reg <= 9'h0;
         col_reg <= 9'h0;
         wdata_reg <= 9'h0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 9'h0;
         mux_addr_pins <= 9'h0;
         row_strobe_n <= 1'b1;
         col_strobe_n <= 1'b1;
         parity_col_strobe_n <= 1'b1;
         write_enable_n <= 1'b1;
         main_data_out <= 8'h0;
         main_data_oe <= 1'b0;
         parity_data_in <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         req_ready <= 1'b0;
         cnt_reg <= cnt_reg + 32'h1;
         pc_reg <= pc_reg + 32'h1;
         ras_reg <= ras_reg + 32'h1;
         case (state_reg)
            S_PAUSE:
            begin
               if (cnt_reg >= INIT_PAUSE_CYC - 1)
               begin
                  cnt_reg <= 32'h0;
                  state_reg <= S_PRE;
               end
            end
            S_IDLE:
            begin
               if (take)
               begin
                  op_reg <= req_op;
                  row_reg <= req_addr[17:9];
                  col_reg <= req_addr[8:0];
                  wdata_reg <= req_wdata;
                  mux_addr_pins <= req_addr[17:9];
                  cnt_reg <= 32'h0;
                  state_reg <= S_ROW;
               end
               else if (ref_pend_reg)
               begin
                  cnt_reg <= 32'h0;
                  state_reg <= S_REF_SET;
               end
               else
                  req_ready <= 1'b1;
            end
            S_ROW:
            begin
               row_strobe_n <= 1'b0;
               ras_reg <= 32'h0;
               cnt_reg <= 32'h0;
               state_reg <= S_COLADDR;
            end
            S_COLADDR:
            begin
               if (cnt_reg >= T_RAH - 1)
               begin
                  mux_addr_pins <= col_reg;
                  write_enable_n <= (op_reg != `DMC_OP_WRITE);
                  main_data_out <= wdata_reg[7:0];
                  main_data_oe <= (op_reg == `DMC_OP_WRITE);
                  parity_data_in <= wdata_reg[8];
                  if (cnt_reg >= T_RCD - 1)
                  begin
                     col_strobe_n <= (op_reg == `DMC_OP_PARITY_RMW);
                     parity_col_strobe_n <= 1'b0;
                     pc_reg <= 32'h0;
                     cnt_reg <= 32'h0;
                     state_reg <= S_COL;
                  end
               end
            end
            S_COL:
            begin
               // read data sampled after column access plus synchroniser delay
               if (op_reg == `DMC_OP_PARITY_RMW && cnt_reg >= T_CWD && cnt_reg >= T_CAC &&
                  ras_reg >= T_RAC)
               begin
                  rsp_rdata <= {par_s2_reg, 8'h0};
                  write_enable_n <= 1'b0;
                  cnt_reg <= 32'h0;
                  state_reg <= S_RMW;
               end
               else if (op_reg != `DMC_OP_PARITY_RMW && cnt_reg >= T_CAC && cnt_reg >= T_CAS &&
                  ras_reg >= T_RAC)
               begin
                  if (op_reg == `DMC_OP_READ)
                  begin
                     rsp_rdata <= {par_s2_reg, main_s2_reg};
                  end
                  rsp_valid <= 1'b1;
                  cnt_reg <= 32'h0;
                  state_reg <= S_COLUP;
               end
            end
            S_RMW:
            begin
               if (cnt_reg >= T_WP)
               begin
                  rsp_valid <= 1'b1;
                  cnt_reg <= 32'h0;
                  state_reg <= S_COLUP;
               end
            end
            S_COLUP:
            begin
               col_strobe_n <= 1'b1;
               parity_col_strobe_n <= 1'b1;
               main_data_oe <= 1'b0;
               cnt_reg <= 32'h0;
               state_reg <= S_PAGE;
            end
            S_PAGE:
            begin
               write_enable_n <= 1'b1;
               if (cnt_reg >= T_RRH && ras_reg >= T_RAS)
               begin
                  if (page_hit && cnt_reg >= T_CP && pc_reg >= T_PC)
                  begin
                     op_reg <= req_op;
                     col_reg <= req_addr[8:0];
                     wdata_reg <= req_wdata;
                     pc_reg <= 32'h0;
                     cnt_reg <= T_RCD;
                     state_reg <= S_COLADDR;
                  end
                  else if (!req_valid || !page_hit)
                  begin
                     row_strobe_n <= 1'b1;
                     cnt_reg <= 32'h0;
                     state_reg <= S_PRE;
                  end
               end
            end
            S_PRE:
            begin
               if (cnt_reg >= T_RP - 1)
               begin
                  cnt_reg <= 32'h0;
                  if (!init_done)
                     state_reg <= S_REF_SET;
                  else
                  begin
                     req_ready <= !ref_pend_reg;
                     state_reg <= S_IDLE;
                  end
               end
            end
            S_REF_SET:
            begin
               if (cnt_reg >= T_RPC - 1)
               begin
                  col_strobe_n <= 1'b0;
                  parity_col_strobe_n <= 1'b0;
               end
               if (cnt_reg >= T_RPC + T_FCS)
               begin
                  row_strobe_n <= 1'b0;
                  cnt_reg <= 32'h0;
                  state_reg <= S_REF_ROW;
               end
            end
            S_REF_ROW:
            begin
               if (cnt_reg >= T_FCH)
               begin
                  col_strobe_n <= 1'b1;
                  parity_col_strobe_n <= 1'b1;
               end
               if (cnt_reg >= T_RAS)
               begin
                  row_strobe_n <= 1'b1;
                  cnt_reg <= 32'h0;
                  if (!init_done)
                  begin
                     init_cnt_reg <= init_cnt_reg + 4'h1;
                     if (init_cnt_reg == `DMC_INIT_REFRESHES - 1)
                        init_done <= 1'b1;
                  end
                  state_reg <= S_PRE;
               end
            end
            default:
               state_reg <= S_PAUSE;
         endcase
      end
   end
endmodule // dmc_ctrl

/* dv/dmc_ctrl_assertions.sv */
module dmc_ctrl_checker #(parameter INIT_PAUSE_CYC = 40000) (
   input wire clock,
   input wire nrst,
   input wire init_done,
   input wire [8:0] mux_addr_pins,
   input wire row_strobe_n,
   input wire col_strobe_n,
   input wire parity_col_strobe_n,
   input wire write_enable_n,
   input wire main_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] up_reg;
   logic [7:0] gap_reg;
   logic [3:0] cbr_reg;
   always @(posedge clock)
   begin
      up_reg <= nrst ? up_reg + 32'h1 : 32'h0;
      gap_reg <= row_strobe_n ? 8'hff : $fell(col_strobe_n) ? 8'h01 :
         gap_reg + {7'h0, gap_reg != 8'hff};
      cbr_reg <= !nrst ? 4'h0 :
         cbr_reg + {3'h0, $fell(row_strobe_n) && !col_strobe_n && cbr_reg != 4'hf};
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   a_early_write: assert property ($fell(col_strobe_n) && main_data_oe |-> !write_enable_n)
      else $error("write enable late");
   a_row_hold: assert property ($fell(row_strobe_n) && col_strobe_n |-> $stable(mux_addr_pins) [*2])
      else $error("row address not held");
   a_col_pair: assert property ($fell(col_strobe_n) && !row_strobe_n |-> !parity_col_strobe_n)
      else $error("column strobes split");
   a_cbr_setup: assert property ($fell(row_strobe_n) && !col_strobe_n |->
      $past(col_strobe_n, 4) == 1'b0 && $past(parity_col_strobe_n, 4) == 1'b0) else $error("cbr setup");
   a_page_precharge: assert property ($rose(col_strobe_n) && !row_strobe_n |-> col_strobe_n [*8])
      else $error("column precharge short");
   a_rpc_wait: assert property ($rose(row_strobe_n) && col_strobe_n |-> col_strobe_n [*4])
      else $error("column active too soon");
   a_page_cycle: assert property ($fell(col_strobe_n) && !row_strobe_n |-> gap_reg >= 8'd20)
      else $error("page cycle short");
   a_init_pause: assert property (!row_strobe_n |-> up_reg >= INIT_PAUSE_CYC - 1)
      else $error("row strobe during pause");
   a_init_refresh: assert property ($rose(init_done) |-> cbr_reg >= 4'h8)
      else $error("too few init refreshes");
   c_write: cover property ($fell(col_strobe_n) && !write_enable_n);
   c_rmw: cover property ($fell(parity_col_strobe_n) && col_strobe_n && !row_strobe_n);
   c_page: cover property ($fell(col_strobe_n) && gap_reg != 8'hff);
endmodule // dmc_ctrl_checker
bind dmc_ctrl dmc_ctrl_checker #(.INIT_PAUSE_CYC(INIT_PAUSE_CYC)) chk_u (.clock(clock), .nrst(nrst),
   .init_done(init_done), .mux_addr_pins(mux_addr_pins), .row_strobe_n(row_strobe_n),
   .col_strobe_n(col_strobe_n), .parity_col_strobe_n(parity_col_strobe_n),
   .write_enable_n(write_enable_n), .main_data_oe(main_data_oe));

/* dv/dmc_dram_model.sv */
module dmc_dram_model (
   input wire clock,
   input wire [8:0] mux_addr_pins,
   input wire row_strobe_n,
   input wire col_strobe_n,
   input wire parity_col_strobe_n,
   input wire write_enable_n,
   input wire [7:0] main_data_out,
   input wire main_data_oe,
   input wire parity_data_in,
   output logic [7:0] main_data_in = 8'h00,
   output logic parity_data_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] mem [logic [17:0]];
   logic [8:0] row_reg = 9'h000;
   logic [17:0] addr_reg = 18'h0;
   logic [7:0] refresh_row_reg = 8'h00;
   logic rd_reg = 1'b1;
   logic row_q = 1'b1;
   logic par_q = 1'b1;
   logic we_q = 1'b1;
   int row_t = 99;
   int col_t = 99;
   logic [8:0] word, held;
   logic ok;
   always @(posedge clock)
   begin
      row_t <= row_t + 1;
      col_t <= col_t + 1;
      held = mem.exists(addr_reg) ? mem[addr_reg] : 9'h000;
      word = mem.exists({row_reg, mux_addr_pins}) ? mem[{row_reg, mux_addr_pins}] : 9'h000;
      if (row_q && !row_strobe_n)
      begin
         row_t <= 1;
         if (!col_strobe_n && !parity_col_strobe_n) refresh_row_reg <= refresh_row_reg + 8'h01;
         else row_reg <= mux_addr_pins;
      end
      if (!row_strobe_n && par_q && !parity_col_strobe_n)
      begin
         col_t <= 1;
         addr_reg <= {row_reg, mux_addr_pins};
         rd_reg <= write_enable_n;
         word[8] = parity_data_in;
         if (!col_strobe_n) word[7:0] = main_data_oe ? main_data_out : ~main_data_in;
         if (!write_enable_n) mem[{row_reg, mux_addr_pins}] = word;
      end
      if (we_q && !write_enable_n && rd_reg && !parity_col_strobe_n && col_strobe_n)
         mem[addr_reg] = {parity_data_in, held[7:0]};
      ok = rd_reg && !row_strobe_n && col_t >= 9 && row_t >= 19;
      main_data_in <= ok && !col_strobe_n ? held[7:0] : ~main_data_in;
      parity_data_out <= ok && !parity_col_strobe_n ? held[8] : ~parity_data_out;
      row_q <= row_strobe_n;
      par_q <= parity_col_strobe_n;
      we_q <= write_enable_n;
   end
endmodule // dmc_dram_model

/* dv/dram_module_x9_async_interface_bench.sv */
module dram_module_x9_async_interface_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic req_page = 1'b0;
   logic [1:0] req_op = 2'h0;
   logic [17:0] req_addr = 18'h0;
   logic [8:0] req_wdata = 9'h0;
   logic [31:0] seed = 32'h7;
   logic [8:0] got, want;
   logic [8:0] exp_mem [logic [17:0]];
   logic row_q = 1'b1;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int cbr_n = 0;
   wire req_ready, rsp_valid, init_done, row_strobe_n, col_strobe_n, parity_col_strobe_n;
   wire write_enable_n, main_data_oe, parity_data_in, parity_data_out;
   wire [8:0] rsp_rdata, mux_addr_pins;
   wire [7:0] main_data_out, main_data_in;
   always #2.5 clock = ~clock;
   dmc_ctrl #(.INIT_PAUSE_CYC(50), .REFRESH_INTERVAL_CYC(400)) dut_u (.clock(clock), .nrst(nrst),
      .req_valid(req_valid), .req_op(req_op), .req_page(req_page), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .init_done(init_done), .mux_addr_pins(mux_addr_pins), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .parity_col_strobe_n(parity_col_strobe_n),
      .write_enable_n(write_enable_n), .main_data_out(main_data_out), .main_data_oe(main_data_oe),
      .main_data_in(main_data_in), .parity_data_in(parity_data_in),
      .parity_data_out(parity_data_out));
   dmc_dram_model mdl_u (.clock(clock), .mux_addr_pins(mux_addr_pins), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .parity_col_strobe_n(parity_col_strobe_n),
      .write_enable_n(write_enable_n), .main_data_out(main_data_out), .main_data_oe(main_data_oe),
      .parity_data_in(parity_data_in), .main_data_in(main_data_in),
      .parity_data_out(parity_data_out));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic access(input logic [1:0] op, input logic pg, input logic [17:0] a, input logic [8:0] d);
      int t;
      logic seen;
      t = 0;
      seen = 1'b0;
      req_valid <= 1'b1;
      req_op <= op;
      req_page <= pg;
      req_addr <= a;
      req_wdata <= d;
      while (!seen && t < 400 && (t == 0 || req_valid))
      begin
         @(posedge clock);
         t++;
         if (req_ready === 1'b1 || rsp_valid === 1'b1) req_valid <= 1'b0;
         seen = rsp_valid === 1'b1;
         got = rsp_rdata;
      end
      while (!seen && t < 400)
      begin
         @(posedge clock);
         t++;
         seen = rsp_valid === 1'b1;
         got = rsp_rdata;
      end
      check({8'h00, seen}, 9'h001);
      want = exp_mem.exists(a) ? exp_mem[a] : 9'h000;
      if (op == 2'h0) check(got, want);
      if (op == 2'h1) exp_mem[a] = d;
      if (op == 2'h2) check({8'h00, got[8]}, {8'h00, want[8]});
      if (op == 2'h2) exp_mem[a] = {d[8], want[7:0]};
      @(posedge clock);
   endtask
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      row_q <= row_strobe_n;
      if (row_q && !row_strobe_n && !col_strobe_n && !init_done) cbr_n <= cbr_n + 1;
      if (cyc == 30000)
      begin
         n_errors = n_errors + 1;
         give_verdict();
      end
   end
   initial
   begin
      logic [31:0] r;
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      while (init_done !== 1'b1 && cyc < 3000) @(posedge clock);
      check({8'h00, init_done}, 9'h001);
      check({8'h00, cbr_n >= 8}, 9'h001);
      access(2'h1, 1'b0, 18'h00000, 9'h1ff);
      access(2'h1, 1'b0, 18'h3ffff, 9'h000);
      access(2'h2, 1'b0, 18'h3ffff, 9'h100);
      access(2'h0, 1'b0, 18'h3ffff, 9'h000);
      access(2'h0, 1'b1, 18'h00000, 9'h000);
      for (int i = 0; i < 40; i++)
      begin
         r = xs();
         access(r[1:0] == 2'h3 ? 2'h0 : r[1:0], r[2], {7'h00, r[4:3], r[13:5]}, r[22:14]);
      end
      repeat (900) @(posedge clock);
      foreach (exp_mem[k]) access(2'h0, 1'b1, k, 9'h000);
      give_verdict();
   end
endmodule // dram_module_x9_async_interface_bench
